// ===== rtl/apc_ctrl.sv
// Amplifier and charge-pump clock control register bank
//
// The address-and-strobe port was decided locally.
`default_nettype none

// One software register, loaded by a write strobe to its own address.
// Unused bits are cut off by the caller before they reach the cell.
module apc_reg_cell #(
    parameter int           W    = 8,
    parameter logic [7:0]   ADDR = 8'h00,
    parameter logic [W-1:0] RST  = '0
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    // Register port
    input  wire logic [7:0]   addr_i,
    input  wire logic [W-1:0] wdata_i,
    input  wire logic         wr_i,
    // Stored value
    output logic      [W-1:0] q_o
);

    // Whole-address match, so no alias of the offset writes the register
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            q_o <= RST;
        else if (wr_i && (addr_i == ADDR))
            q_o <= wdata_i;
    end

endmodule : apc_reg_cell

// Power-of-two clock divider behind a fixed prescale.
// The output is a flop, so the analog side never sees a decode glitch.
module apc_clk_div #(
    parameter int DIV_W    = 4,
    parameter int PRE_LOG2 = 2,
    parameter int CNT_W    = 20
) (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    // Divider control
    input  wire logic             run_i,
    input  wire logic [DIV_W-1:0] div_i,
    // Divided clock
    output logic                  clk_o
);

    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] half;
    logic             tog;

    // Half period in clock cycles: 2^(PRE_LOG2 - 1 + div)
    assign half = CNT_W'(1) << (PRE_LOG2 - 1 + int'(div_i));
    // Compare with >= so a smaller divider ends the running half at once
    assign tog  = (cnt_r >= half - CNT_W'(1));

    // Count and toggle; a stopped divider sits low with a cleared count
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cnt_r <= '0;
            clk_o <= 1'b0;
        end
        else if (!run_i)
        begin
            cnt_r <= '0;
            clk_o <= 1'b0;
        end
        else if (tog)
        begin
            cnt_r <= '0;
            clk_o <= ~clk_o;
        end
        else
            cnt_r <= cnt_r + CNT_W'(1);
    end

endmodule : apc_clk_div

// Register bank top: five registers, two dividers, registered controls.
// Every control output lags its register by one cycle.
module apc_ctrl (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    // Register port
    input  wire logic [7:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    output logic      [7:0] rdata_o,
    // Analog controls
    output logic            amp_en_o,
    output logic      [2:0] gain_sel_o,
    output logic            gain_reserved_o,
    output logic      [1:0] chop_low_freq_o,
    output logic            bandgap_en_o,
    output logic            pump_reg_en_o,
    output logic      [3:0] pump_ctrl_o,
    // Input routing one-hot: diff, pos/cm, neg/cm, short, sensor
    output logic      [4:0] route_o,
    output logic            sensor_to_pos_o,
    output logic            fixed_to_neg_o,
    // Divided clocks
    output logic            pump_clk_o,
    output logic            chop_clk_o
);

    logic [7:0]             amp_mode_r;
    logic [2:0]             chan_r;
    logic [2:0]             chop_div_r;
    logic [3:0]             pump_div_r;
    logic [7:0]             pump_mode_r;
    logic [4:0]             route_nxt;

    // Amplifier mode; bit 7 does not exist and is stored as zero
    apc_reg_cell #(
        .W    (8),
        .ADDR (apc_pkg::ADDR_AMP_MODE),
        .RST  (apc_pkg::AMP_MODE_RST)
    ) amp_mode_inst (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .addr_i  (addr_i),
        .wdata_i ({1'b0, wdata_i[6:0]}),
        .wr_i    (wr_i),
        .q_o     (amp_mode_r)
    );

    // Input channel select, three bits
    apc_reg_cell #(
        .W    (3),
        .ADDR (apc_pkg::ADDR_AMP_INPUT),
        .RST  (apc_pkg::CHAN_RST)
    ) chan_inst (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .addr_i  (addr_i),
        .wdata_i (wdata_i[2:0]),
        .wr_i    (wr_i),
        .q_o     (chan_r)
    );

    // Chopper clock divider, write-only
    apc_reg_cell #(
        .W    (3),
        .ADDR (apc_pkg::ADDR_CHOP_DIV),
        .RST  (apc_pkg::CHOP_DIV_RST)
    ) chop_div_inst (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .addr_i  (addr_i),
        .wdata_i (wdata_i[2:0]),
        .wr_i    (wr_i),
        .q_o     (chop_div_r)
    );

    // Pump clock divider, write-only, four bits
    apc_reg_cell #(
        .W    (4),
        .ADDR (apc_pkg::ADDR_PUMP_DIV),
        .RST  (apc_pkg::PUMP_DIV_RST)
    ) pump_div_inst (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .addr_i  (addr_i),
        .wdata_i (wdata_i[3:0]),
        .wr_i    (wr_i),
        .q_o     (pump_div_r)
    );

    // Pump mode; bit 3 is a status position and is stored as zero
    apc_reg_cell #(
        .W    (8),
        .ADDR (apc_pkg::ADDR_PUMP_MODE),
        .RST  (apc_pkg::PUMP_MODE_RST)
    ) pump_mode_inst (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .addr_i  (addr_i),
        .wdata_i ({wdata_i[7:4], 1'b0, wdata_i[2:0]}),
        .wr_i    (wr_i),
        .q_o     (pump_mode_r)
    );

    // Read data one cycle after the strobe; write-only registers read zero
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            rdata_o <= 8'h00;
        else if (rd_i)
        begin
            case (addr_i)
                apc_pkg::ADDR_AMP_MODE:  rdata_o <= amp_mode_r;
                apc_pkg::ADDR_AMP_INPUT: rdata_o <= {5'h00, chan_r};
                apc_pkg::ADDR_PUMP_MODE: rdata_o <= pump_mode_r;
                default:                 rdata_o <= 8'h00;
            endcase
        end
        else
            rdata_o <= 8'h00;
    end

    // Pump clock: cpu clock / 4 / 2^divider, always running
    apc_clk_div #(
        .DIV_W    (4),
        .PRE_LOG2 (apc_pkg::PUMP_PRE_LOG2),
        .CNT_W    (apc_pkg::CNT_W)
    ) pump_clk_inst (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .run_i   (1'b1),
        .div_i   (pump_div_r),
        .clk_o   (pump_clk_o)
    );

    // Chopper clock: cpu clock / 32 / 2^divider.
    // Held low and cleared while the amplifier is off, so it starts clean.
    apc_clk_div #(
        .DIV_W    (3),
        .PRE_LOG2 (apc_pkg::CHOP_PRE_LOG2),
        .CNT_W    (apc_pkg::CNT_W)
    ) chop_clk_inst (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .run_i   (amp_mode_r[apc_pkg::AMP_EN_BIT]),
        .div_i   (chop_div_r),
        .clk_o   (chop_clk_o)
    );

    // Channel decode to one-hot routing
    always_comb
    begin
        case (chan_r)
            apc_pkg::CH_DIFF:   route_nxt = 5'h01;
            apc_pkg::CH_POS_CM: route_nxt = 5'h02;
            apc_pkg::CH_NEG_CM: route_nxt = 5'h04;
            apc_pkg::CH_SHORT:  route_nxt = 5'h08;
            apc_pkg::CH_TEMP:   route_nxt = 5'h10;
            default:            route_nxt = 5'h00;
        endcase
    end

    // Registered amplifier controls
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            amp_en_o        <= 1'b0;
            gain_sel_o      <= apc_pkg::GAIN_UNITY;
            gain_reserved_o <= 1'b0;
            chop_low_freq_o <= 2'h0;
            bandgap_en_o    <= 1'b0;
        end
        else
        begin
            amp_en_o        <= amp_mode_r[apc_pkg::AMP_EN_BIT];
            gain_sel_o      <= amp_mode_r[apc_pkg::GAIN_LSB +: 3];
            gain_reserved_o <= amp_mode_r[3] & (amp_mode_r[2:1] != 2'h3);
            chop_low_freq_o <= amp_mode_r[apc_pkg::CLF_LSB +: 2];
            bandgap_en_o    <= amp_mode_r[apc_pkg::BG_EN_BIT];
        end
    end

    // Registered pump controls; the upper nibble goes out unchanged
    // so the supply enables follow software one cycle later
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            pump_reg_en_o   <= 1'b0;
            pump_ctrl_o     <= 4'h0;
        end
        else
        begin
            pump_reg_en_o   <= pump_mode_r[apc_pkg::PUMP_EN_BIT];
            pump_ctrl_o     <= {pump_mode_r[7:4]};
        end
    end

    // Registered input routing; reserved codes open every switch
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            route_o         <= 5'h00;
            sensor_to_pos_o <= 1'b0;
            fixed_to_neg_o  <= 1'b0;
        end
        else
        begin
            route_o         <= route_nxt;
            sensor_to_pos_o <= route_nxt[4];
            fixed_to_neg_o  <= route_nxt[4];
        end
    end

endmodule : apc_ctrl
`default_nettype wire

// ===== rtl/apc_pkg.sv
// Package: register map, field layout, reset values and divider constants
`default_nettype none
package apc_pkg;
    // Register offsets
    localparam logic [7:0] ADDR_AMP_MODE     = 8'h90;
    localparam logic [7:0] ADDR_AMP_INPUT    = 8'h91;
    localparam logic [7:0] ADDR_CHOP_DIV     = 8'h92;
    localparam logic [7:0] ADDR_PUMP_MODE    = 8'h95;
    localparam logic [7:0] ADDR_PUMP_DIV     = 8'h96;
    // Amplifier mode fields, then the pump mode enable bit
    localparam int AMP_EN_BIT   = 0;
    localparam int GAIN_LSB     = 1;
    localparam int CLF_LSB      = 4;
    localparam int BG_EN_BIT    = 6;
    localparam int PUMP_EN_BIT  = 0;
    // Reset values
    localparam logic [7:0] AMP_MODE_RST  = 8'h0e;
    localparam logic [2:0] CHAN_RST      = 3'h0;
    localparam logic [2:0] CHOP_DIV_RST  = 3'h0;
    localparam logic [3:0] PUMP_DIV_RST  = 4'h0;
    localparam logic [7:0] PUMP_MODE_RST = 8'h00;
    // Fixed prescales ahead of the power-of-two stage
    localparam int PUMP_PRE_LOG2 = 2;
    localparam int CHOP_PRE_LOG2 = 5;
    localparam int CNT_W         = 20;
    // Gain codes
    localparam logic [2:0] GAIN_12P5  = 3'h0;
    localparam logic [2:0] GAIN_50    = 3'h1;
    localparam logic [2:0] GAIN_100   = 3'h2;
    localparam logic [2:0] GAIN_200   = 3'h3;
    localparam logic [2:0] GAIN_UNITY = 3'h7;
    // Channel codes
    localparam logic [2:0] CH_DIFF    = 3'h0;
    localparam logic [2:0] CH_POS_CM  = 3'h1;
    localparam logic [2:0] CH_NEG_CM  = 3'h2;
    localparam logic [2:0] CH_SHORT   = 3'h3;
    localparam logic [2:0] CH_TEMP    = 3'h5;
endpackage : apc_pkg
`default_nettype wire

// ===== verif/apc_analog_model.sv
// Analog side model: measures a divided clock period in cpu cycles
`default_nettype none
module apc_analog_model (
    // Clock and divided clock under measure
    input  wire logic        clk_i,
    input  wire logic        tick_i,
    // Last measured period
    output logic      [15:0] period_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic        prev_r = 1'b0;
    logic [15:0] cnt_r  = 16'h0000;
    // Each rising edge closes one period
    always_ff @(posedge clk_i)
    begin
        prev_r <= tick_i;
        cnt_r  <= (tick_i && !prev_r) ? 16'h0001 : cnt_r + 16'h0001;
        if (tick_i && !prev_r)
            period_o <= cnt_r;
    end
endmodule : apc_analog_model
`default_nettype wire

// ===== verif/apc_ctrl_chk.sv
// Port assertions for the amplifier and pump clock control bank
`default_nettype none
module apc_ctrl_chk (
    // Clock, reset, register port
    input wire logic       clk_i,
    input wire logic       rst_n_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic       wr_i,
    input wire logic       rd_i,
    input wire logic [7:0] rdata_o,
    // Controls
    input wire logic       amp_en_o,
    input wire logic [2:0] gain_sel_o,
    input wire logic       gain_reserved_o,
    input wire logic       bandgap_en_o,
    input wire logic       pump_reg_en_o,
    input wire logic [4:0] route_o,
    input wire logic       sensor_to_pos_o,
    input wire logic       chop_clk_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // Register writes, outputs follow two edges later
    sequence s_wr_mode;
        wr_i && addr_i == apc_pkg::ADDR_AMP_MODE;
    endsequence
    sequence s_wr_pump;
        wr_i && addr_i == apc_pkg::ADDR_PUMP_MODE;
    endsequence
    AST_AMP_EN: assert property (s_wr_mode |-> ##2 amp_en_o == $past(wdata_i[0], 2))
        else $error("amp enable wrong");
    AST_GAIN: assert property (s_wr_mode |-> ##2 gain_sel_o == $past(wdata_i[3:1], 2))
        else $error("gain wrong");
    AST_GAIN_RSV: assert property (s_wr_mode |-> ##2
        gain_reserved_o == ($past(wdata_i[3:1], 2) inside {3'h4, 3'h5, 3'h6}))
        else $error("reserved gain flag wrong");
    AST_BG: assert property (s_wr_mode |-> ##2 bandgap_en_o == $past(wdata_i[6], 2))
        else $error("bandgap enable wrong");
    AST_PUMP: assert property (s_wr_pump |-> ##2 pump_reg_en_o == $past(wdata_i[0], 2))
        else $error("pump enable wrong");
    AST_SENSOR: assert property (sensor_to_pos_o |-> route_o == 5'h10)
        else $error("sensor route wrong");
    AST_CHOP_OFF: assert property (!amp_en_o [*2] |-> !chop_clk_o)
        else $error("chopper clock runs while off");
    AST_WO_RD: assert property (rd_i && (addr_i == apc_pkg::ADDR_CHOP_DIV ||
        addr_i == apc_pkg::ADDR_PUMP_DIV) |=> rdata_o == 8'h00)
        else $error("write-only read not zero");
endmodule : apc_ctrl_chk
bind apc_ctrl apc_ctrl_chk apc_ctrl_chk_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .amp_en_o(amp_en_o), .gain_sel_o(gain_sel_o), .gain_reserved_o(gain_reserved_o),
    .bandgap_en_o(bandgap_en_o), .pump_reg_en_o(pump_reg_en_o), .route_o(route_o),
    .sensor_to_pos_o(sensor_to_pos_o), .chop_clk_o(chop_clk_o));
`default_nettype wire

// ===== verif/apc_ctrl_test.sv
// Self-checking bench for the amplifier and pump clock control bank
`default_nettype none
module apc_ctrl_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0, rst_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
    logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o;
    logic amp_en_o, gain_reserved_o, bandgap_en_o, pump_reg_en_o, pump_clk_o;
    logic chop_clk_o, sensor_to_pos_o, fixed_to_neg_o;
    logic [2:0] gain_sel_o;
    logic [1:0] chop_low_freq_o;
    logic [3:0] pump_ctrl_o;
    logic [4:0] route_o;
    logic [15:0] pump_per, chop_per;
    int error_cnt = 0;
    int n_compared = 0;
    apc_ctrl apc_ctrl_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .amp_en_o(amp_en_o), .gain_sel_o(gain_sel_o), .gain_reserved_o(gain_reserved_o),
        .chop_low_freq_o(chop_low_freq_o), .bandgap_en_o(bandgap_en_o),
        .pump_reg_en_o(pump_reg_en_o), .pump_ctrl_o(pump_ctrl_o), .route_o(route_o),
        .sensor_to_pos_o(sensor_to_pos_o), .fixed_to_neg_o(fixed_to_neg_o),
        .pump_clk_o(pump_clk_o), .chop_clk_o(chop_clk_o));
    apc_analog_model pump_inst (.clk_i(clk_i), .tick_i(pump_clk_o), .period_o(pump_per));
    apc_analog_model chop_inst (.clk_i(clk_i), .tick_i(chop_clk_o), .period_o(chop_per));
    // 200 MHz clock
    initial forever #2.5 clk_i = ~clk_i;
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("BAD %0t seen %h exp %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        #1;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        chk(rdata_o, exp);
    endtask : rd
    task automatic stop_test;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : stop_test
    task automatic t_mode;
        for (int i = 0; i < 8; i++)
        begin
            wr(apc_pkg::ADDR_AMP_MODE, {4'hf, i[2:0], 1'b1});
            chk(amp_en_o, 1'b1);
            chk(gain_sel_o, i[2:0]);
            chk(gain_reserved_o, i inside {4, 5, 6});
            chk(bandgap_en_o, 1'b1);
            chk(chop_low_freq_o, 2'h3);
            rd(apc_pkg::ADDR_AMP_MODE, {4'h7, i[2:0], 1'b1});
        end
        wr(apc_pkg::ADDR_AMP_MODE, 8'h0e);
        repeat (100) @(posedge clk_i);
        chk({amp_en_o, bandgap_en_o, chop_clk_o}, 3'h0);
        $display("t_mode done");
    endtask : t_mode
    task automatic t_chan;
        for (int i = 0; i < 8; i++)
        begin
            wr(apc_pkg::ADDR_AMP_INPUT, i[7:0]);
            chk(route_o, i < 4 ? 5'h01 << i : (i == 5 ? 5'h10 : 5'h00));
            chk({sensor_to_pos_o, fixed_to_neg_o}, i == 5 ? 2'h3 : 2'h0);
            rd(apc_pkg::ADDR_AMP_INPUT, {5'h00, i[2:0]});
        end
        wr(8'h80, 8'hff);
        rd(8'h80, 8'h00);
        $display("t_chan done");
    endtask : t_chan
    task automatic t_clocks;
        wr(apc_pkg::ADDR_AMP_MODE, 8'h40);
        wr(apc_pkg::ADDR_PUMP_DIV, 8'h0b);
        wr(apc_pkg::ADDR_PUMP_MODE, 8'h05);
        chk(pump_reg_en_o, 1'b1);
        repeat (24600) @(posedge clk_i);
        chk(pump_per, 16'd8192);
        wr(apc_pkg::ADDR_PUMP_DIV, 8'h01);
        repeat (40) @(posedge clk_i);
        chk(pump_per, 16'd8);
        wr(apc_pkg::ADDR_PUMP_MODE, 8'hfd);
        chk(pump_ctrl_o, 4'hf);
        rd(apc_pkg::ADDR_PUMP_MODE, 8'hf5);
        wr(apc_pkg::ADDR_AMP_MODE, 8'h77);
        for (int d = 0; d < 3; d += 2)
        begin
            wr(apc_pkg::ADDR_CHOP_DIV, d[7:0]);
            repeat (420) @(posedge clk_i);
            chk(chop_per, 16'd32 << d);
        end
        rd(apc_pkg::ADDR_CHOP_DIV, 8'h00);
        rd(apc_pkg::ADDR_PUMP_DIV, 8'h00);
        $display("t_clocks done");
    endtask : t_clocks
    task automatic t_reset;
        @(posedge clk_i);
        rst_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
        #1;
        chk({pump_reg_en_o, pump_ctrl_o, pump_clk_o, chop_clk_o}, 7'h00);
        rd(apc_pkg::ADDR_AMP_MODE, apc_pkg::AMP_MODE_RST);
        rd(apc_pkg::ADDR_PUMP_MODE, 8'h00);
        repeat (20) @(posedge clk_i);
        chk(pump_per, 16'd4);
        $display("t_reset done");
    endtask : t_reset
    // Main sequence
    initial
    begin
        repeat (4) @(posedge clk_i);
        rst_n_i <= 1'b1;
        #1;
        chk(gain_sel_o, 3'h7);
        rd(apc_pkg::ADDR_AMP_MODE, 8'h0e);
        t_mode();
        t_chan();
        t_clocks();
        t_reset();
        stop_test();
    end
    // Watchdog
    initial
    begin
        #(5 * 60000);
        error_cnt++;
        stop_test();
    end
endmodule : apc_ctrl_test
`default_nettype wire
